// *** tcc_pkg.sv ***
// timer counter core package: register offsets, field layout, reset values
// assumes a 32-bit ahb-lite slave with one register per aligned word
package tcc_pkg;
    // register byte addresses
    localparam logic [7:0] TCC_ADDR_STATUS_CTRL = 8'h00;
    localparam logic [7:0] TCC_ADDR_CNT_HIGH = 8'h04;
    localparam logic [7:0] TCC_ADDR_CNT_LOW = 8'h08;
    localparam logic [7:0] TCC_ADDR_MOD_HIGH = 8'h0C;
    localparam logic [7:0] TCC_ADDR_MOD_LOW = 8'h10;
    localparam logic [7:0] TCC_ADDR_CHAN_CTRL = 8'h14;
    // status/control field positions
    localparam int TCC_BIT_OVF = 7;
    localparam int TCC_BIT_OVF_IE = 6;
    localparam int TCC_BIT_HALT = 5;
    localparam int TCC_BIT_CRST = 4;
    localparam int TCC_SEL_HI = 2;
    // channel control field positions
    localparam int TCC_BIT_CH_FLAG = 7;
    localparam int TCC_BIT_CH_IE = 6;
    // reset values and codes
    localparam logic [2:0] TCC_SEL_RESET = 3'h0;
    localparam logic [2:0] TCC_SEL_EXT = 3'h7;
    localparam logic [15:0] TCC_CNT_RESET = 16'h0000;
    localparam logic [15:0] TCC_CNT_ONE = 16'h0001;
    localparam logic [15:0] TCC_MOD_RESET = 16'hFFFF;
    localparam logic [5:0] TCC_PRE_RESET = 6'h00;
    localparam logic [5:0] TCC_PRE_ONE = 6'h01;
    localparam logic [1:0] TCC_HTRANS_NONSEQ = 2'h2;
    // captured ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } tcc_aphase_t;
    // software-visible control bits
    typedef struct packed {
        logic ovf_ie;
        logic halt;
        logic [2:0] sel;
        logic ch_ie;
    } tcc_ctrl_t;
endpackage : tcc_pkg

// *** tcc_sync.sv ***
// two-flop synchroniser for one pin level
// assumes the input is asynchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module tcc_sync (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;
    // first stage feeds only the second stage
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : tcc_sync
`default_nettype wire

// *** tcc_core.sv ***
// timer counter core: prescaler, 16-bit modulo counter, flags, ahb-lite registers
// assumes one 125 MHz bus clock, synchronous reset, single word ahb transfers
//
// Functional notes
// - counter equals modulo: set flag, then restart
// - flag clears by read-then-zero write only
// - overflow between read and write keeps flag
// - overflow request when flag and enable set
// - channel flag gated by channel enable
// - halt bit holds counter, set at reset
// - counter reset clears counter, prescaler, reads zero
// - halt plus counter reset holds zero
// - select field: bus divide or external pin
// - external clock selected forces pin input
// - high byte read latches low byte
// - counter read-only, cleared by resets
// - modulo high write suppresses overflow until low
// - modulo registers reset to all ones
// - wait mode keeps running, interrupt wakes
// - stop mode freezes timer, keeps state
// - debug break holds counter
// - break clears flags only with enable
// - two-step clear spanning break completes after
`timescale 1ns/1ps
`default_nettype none
module tcc_core (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic ext_clk_pin_i,
    input wire logic chan_event_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic break_i,
    input wire logic break_clear_enable_i,
    output logic irq_o,
    output logic wake_o,
    output logic ext_pin_force_input_o
);
    tcc_pkg::tcc_aphase_t aph_q;
    tcc_pkg::tcc_ctrl_t ctrl_q;
    logic ovf_q;
    logic ovf_armed_q;
    logic ch_flag_q;
    logic ch_armed_q;
    logic [15:0] cnt_q;
    logic [15:0] mod_q;
    logic [7:0] mod_high_buf_q;
    logic mod_lock_q;
    logic [7:0] low_latch_q;
    logic latched_q;
    logic [5:0] pre_q;
    logic ext_sync;
    logic ext_prev_q;
    logic crst_req_q;
    logic tick;
    logic ovf_event;
    logic wr_stat;
    logic rd_stat;
    logic wr_chan;
    logic rd_chan;
    logic rd_high;
    logic rd_low;
    logic wr_mod_high;
    logic wr_mod_low;
    logic run;
    logic flag_clr_ok;
    logic irq_cond;

    // decides whether a prescaler value gives a tick for a select code
    // select 7 never reaches this; the pin edge detector ticks instead
    function automatic logic tcc_pre_tick(input logic [2:0] sel, input logic [5:0] pre);
        logic [5:0] mask;
        mask = 6'h00;
        case (sel)
            3'h0: mask = 6'h00;
            3'h1: mask = 6'h01;
            3'h2: mask = 6'h03;
            3'h3: mask = 6'h07;
            3'h4: mask = 6'h0F;
            3'h5: mask = 6'h1F;
            default: mask = 6'h3F;
        endcase
        return (pre & mask) == mask;
    endfunction : tcc_pre_tick

    // pin is asynchronous, so two flops stand before the edge detector
    tcc_sync u_ext_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .async_i(ext_clk_pin_i),
        .sync_o(ext_sync)
    );

    // data-phase strobes from the captured address phase
    always_comb begin
        wr_stat = 1'b0;
        rd_stat = 1'b0;
        wr_chan = 1'b0;
        rd_chan = 1'b0;
        rd_high = 1'b0;
        rd_low = 1'b0;
        wr_mod_high = 1'b0;
        wr_mod_low = 1'b0;
        if (aph_q.valid) begin
            if (aph_q.addr == tcc_pkg::TCC_ADDR_STATUS_CTRL) begin
                wr_stat = aph_q.write;
                rd_stat = !aph_q.write;
            end else if (aph_q.addr == tcc_pkg::TCC_ADDR_CNT_HIGH) begin
                rd_high = !aph_q.write;
            end else if (aph_q.addr == tcc_pkg::TCC_ADDR_CNT_LOW) begin
                rd_low = !aph_q.write;
            end else if (aph_q.addr == tcc_pkg::TCC_ADDR_MOD_HIGH) begin
                wr_mod_high = aph_q.write;
            end else if (aph_q.addr == tcc_pkg::TCC_ADDR_MOD_LOW) begin
                wr_mod_low = aph_q.write;
            end else if (aph_q.addr == tcc_pkg::TCC_ADDR_CHAN_CTRL) begin
                wr_chan = aph_q.write;
                rd_chan = !aph_q.write;
            end
        end
    end

    assign run = !ctrl_q.halt && !stop_mode_i && !break_i && !crst_req_q;
    assign flag_clr_ok = !break_i || break_clear_enable_i;

    // tick from prescaler or synchronised pin rise
    always_comb begin
        if (ctrl_q.sel == tcc_pkg::TCC_SEL_EXT) begin
            tick = ext_sync && !ext_prev_q;
        end else begin
            tick = tcc_pre_tick(ctrl_q.sel, pre_q);
        end
    end
    assign ovf_event = run && tick && (cnt_q == mod_q) && !mod_lock_q;
    // one request term shared by irq and wake, so in wait mode they never disagree
    assign irq_cond = (ovf_q && ctrl_q.ovf_ie) || (ch_flag_q && ctrl_q.ch_ie);

    // ahb address phase capture; every access is zero wait state
    // hsize is ignored: every register is one byte in its own word
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            aph_q <= '0;
        end else if (hready_i) begin
            aph_q.valid <= hsel_i && (htrans_i == tcc_pkg::TCC_HTRANS_NONSEQ);
            aph_q.write <= hwrite_i;
            aph_q.addr <= haddr_i[7:0];
        end
    end

    // control bits written by software
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl_q.ovf_ie <= 1'b0;
            ctrl_q.halt <= 1'b1;
            ctrl_q.sel <= tcc_pkg::TCC_SEL_RESET;
            ctrl_q.ch_ie <= 1'b0;
        end else begin
            if (wr_stat) begin
                ctrl_q.ovf_ie <= hwdata_i[tcc_pkg::TCC_BIT_OVF_IE];
                ctrl_q.halt <= hwdata_i[tcc_pkg::TCC_BIT_HALT];
                ctrl_q.sel <= hwdata_i[tcc_pkg::TCC_SEL_HI:0];
            end
            if (wr_chan) begin
                ctrl_q.ch_ie <= hwdata_i[tcc_pkg::TCC_BIT_CH_IE];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            crst_req_q <= 1'b0;
        end else begin
            crst_req_q <= wr_stat && hwdata_i[tcc_pkg::TCC_BIT_CRST];
        end
    end

    // prescaler and external edge history
    // frozen in stop mode so the divider phase resumes where it left off
    always_ff @(posedge mclk_i) begin
        if (reset_i || crst_req_q) begin
            pre_q <= tcc_pkg::TCC_PRE_RESET;
            ext_prev_q <= 1'b0;
        end else if (!stop_mode_i) begin
            pre_q <= pre_q + tcc_pkg::TCC_PRE_ONE;
            ext_prev_q <= ext_sync;
        end
    end

    // counter; held by halt, stop and break
    // the modulo lock only hides the flag; the wrap itself still happens
    always_ff @(posedge mclk_i) begin
        if (reset_i || crst_req_q) begin
            cnt_q <= tcc_pkg::TCC_CNT_RESET;
        end else if (run && tick) begin
            if (cnt_q == mod_q) begin
                cnt_q <= tcc_pkg::TCC_CNT_RESET;
            end else begin
                cnt_q <= cnt_q + tcc_pkg::TCC_CNT_ONE;
            end
        end
    end

    // high read latches low byte
    // a latch left set across a break holds until the low byte is read
    always_ff @(posedge mclk_i) begin
        if (reset_i || crst_req_q) begin
            low_latch_q <= tcc_pkg::TCC_CNT_RESET[7:0];
            latched_q <= 1'b0;
        end else if (rd_high && !latched_q) begin
            low_latch_q <= cnt_q[7:0];
            latched_q <= 1'b1;
        end else if (rd_low) begin
            latched_q <= 1'b0;
        end
    end

    // modulo high buffered until low written
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mod_q <= tcc_pkg::TCC_MOD_RESET;
            mod_high_buf_q <= tcc_pkg::TCC_MOD_RESET[15:8];
            mod_lock_q <= 1'b0;
        end else if (wr_mod_high) begin
            mod_high_buf_q <= hwdata_i[7:0];
            mod_lock_q <= 1'b1;
        end else if (wr_mod_low) begin
            mod_q <= {mod_high_buf_q, hwdata_i[7:0]};
            mod_lock_q <= 1'b0;
        end
    end

    // overflow flag; set wins over clear
    // a clear that lands on an overflow edge is lost on purpose
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ovf_q <= 1'b0;
            ovf_armed_q <= 1'b0;
        end else if (ovf_event) begin
            ovf_q <= 1'b1;
            ovf_armed_q <= 1'b0;
        end else if (wr_stat && !hwdata_i[tcc_pkg::TCC_BIT_OVF] && ovf_armed_q && flag_clr_ok) begin
            ovf_q <= 1'b0;
            ovf_armed_q <= 1'b0;
        end else if (rd_stat && ovf_q && flag_clr_ok) begin
            ovf_armed_q <= 1'b1;
        end
    end

    // channel flag with same two-step clear
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ch_flag_q <= 1'b0;
            ch_armed_q <= 1'b0;
        end else if (chan_event_i) begin
            ch_flag_q <= 1'b1;
            ch_armed_q <= 1'b0;
        end else if (wr_chan && !hwdata_i[tcc_pkg::TCC_BIT_CH_FLAG] && ch_armed_q && flag_clr_ok) begin
            ch_flag_q <= 1'b0;
            ch_armed_q <= 1'b0;
        end else if (rd_chan && ch_flag_q && flag_clr_ok) begin
            ch_armed_q <= 1'b1;
        end
    end

    // read data registered in the data phase; unmapped reads return zero
    // launched at the address edge so it stands for the whole data phase
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h00000000;
        end else begin
            hrdata_o <= 32'h00000000;
            if (hready_i && hsel_i && htrans_i == tcc_pkg::TCC_HTRANS_NONSEQ && !hwrite_i) begin
                if (haddr_i[7:0] == tcc_pkg::TCC_ADDR_STATUS_CTRL) begin
                    hrdata_o[7:0] <= {ovf_q, ctrl_q.ovf_ie, ctrl_q.halt, 2'h0, ctrl_q.sel};
                end else if (haddr_i[7:0] == tcc_pkg::TCC_ADDR_CNT_HIGH) begin
                    hrdata_o[7:0] <= cnt_q[15:8];
                end else if (haddr_i[7:0] == tcc_pkg::TCC_ADDR_CNT_LOW) begin
                    hrdata_o[7:0] <= latched_q ? low_latch_q : cnt_q[7:0];
                end else if (haddr_i[7:0] == tcc_pkg::TCC_ADDR_MOD_HIGH) begin
                    hrdata_o[7:0] <= mod_q[15:8];
                end else if (haddr_i[7:0] == tcc_pkg::TCC_ADDR_MOD_LOW) begin
                    hrdata_o[7:0] <= mod_q[7:0];
                end else if (haddr_i[7:0] == tcc_pkg::TCC_ADDR_CHAN_CTRL) begin
                    hrdata_o[7:0] <= {ch_flag_q, ctrl_q.ch_ie, 6'h00};
                end
            end
        end
    end

    // interrupt, wake and pin direction outputs
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
            wake_o <= 1'b0;
            ext_pin_force_input_o <= 1'b0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            irq_o <= irq_cond;
            wake_o <= wait_mode_i && irq_cond;
            ext_pin_force_input_o <= ctrl_q.sel == tcc_pkg::TCC_SEL_EXT;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end
endmodule : tcc_core
`default_nettype wire

// *** tcc_core_chk.sv ***
// port checker for the timer counter core
// assumes it is bound to tcc_core and sees one mclk_i domain
`timescale 1ns/1ps
`default_nettype none
module tcc_core_chk (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic wait_mode_i,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic ext_pin_force_input_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    tcc_pkg::tcc_aphase_t aph_q;
    logic rd_dp;
    logic st_wr;
    // address phase seen one cycle back, so data phase checks line up
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            aph_q <= '0;
        end else begin
            aph_q.valid <= hsel_i & hready_i & (htrans_i == tcc_pkg::TCC_HTRANS_NONSEQ);
            aph_q.write <= hwrite_i;
            aph_q.addr <= haddr_i[7:0];
        end
    end
    assign rd_dp = aph_q.valid & ~aph_q.write;
    assign st_wr = aph_q.valid & aph_q.write & (aph_q.addr == tcc_pkg::TCC_ADDR_STATUS_CTRL);
    zero_wait_a: assert property (hreadyout_o)
        else $error("slave stretched a transfer");
    resp_okay_a: assert property (!hresp_o)
        else $error("slave gave an error response");
    rdata_idle_a: assert property (!rd_dp |-> hrdata_o == 32'h0)
        else $error("read data outside a read data phase");
    rdata_upper_a: assert property (rd_dp |-> hrdata_o[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    crst_reads_zero_a: assert property (
        st_wr == 1'b0 && rd_dp && aph_q.addr == tcc_pkg::TCC_ADDR_STATUS_CTRL
        |-> !hrdata_o[tcc_pkg::TCC_BIT_CRST]) else $error("counter reset bit read as one");
    unmapped_zero_a: assert property (
        rd_dp && aph_q.addr > tcc_pkg::TCC_ADDR_CHAN_CTRL |-> hrdata_o == 32'h0)
        else $error("unmapped read returned data");
    pin_forced_a: assert property (
        st_wr && hwdata_i[2:0] == 3'h7 |-> ##[1:3] ext_pin_force_input_o)
        else $error("pin not forced to input");
    pin_released_a: assert property (
        st_wr && hwdata_i[2:0] != 3'h7 |-> ##[1:3] !ext_pin_force_input_o)
        else $error("pin still forced to input");
    wake_gate_a: assert property (wake_o == (irq_o && $past(wait_mode_i)))
        else $error("wake differs from request in wait");
    reset_quiet_a: assert property (disable iff (1'b0)
        reset_i |=> !irq_o && !wake_o && !ext_pin_force_input_o)
        else $error("outputs active after reset");
    cover property (wake_o);
    cover property (ext_pin_force_input_o);
    cover property (rd_dp && hrdata_o[7]);
endmodule : tcc_core_chk
bind tcc_core tcc_core_chk u_chk (.mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .wait_mode_i,
    .irq_o, .wake_o, .ext_pin_force_input_o);
`default_nettype wire

// *** tcc_core_tb.sv ***
// self-checking bench for tcc_core, register tests over ahb-lite
// assumes tcc_pkg, tcc_sync, tcc_core and the checker compile first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tcc_core_tb;
    localparam logic [7:0] AS = tcc_pkg::TCC_ADDR_STATUS_CTRL;
    localparam logic [7:0] ACH = tcc_pkg::TCC_ADDR_CNT_HIGH;
    localparam logic [7:0] ACL = tcc_pkg::TCC_ADDR_CNT_LOW;
    localparam logic [7:0] AMH = tcc_pkg::TCC_ADDR_MOD_HIGH;
    localparam logic [7:0] AML = tcc_pkg::TCC_ADDR_MOD_LOW;
    localparam logic [7:0] ACC = tcc_pkg::TCC_ADDR_CHAN_CTRL;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic ext_pin = 1'b0;
    logic chan_ev = 1'b0;
    logic wait_m = 1'b0;
    logic stop_m = 1'b0;
    logic brk = 1'b0;
    logic bce = 1'b0;
    logic [31:0] hrdata;
    logic hready, hresp, irq, wake, force_in;
    int failures = 0;
    int checks_done = 0;
    logic [31:0] v;
    logic [15:0] a, b;
    always #4 mclk_i = ~mclk_i;
    tcc_core u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .ext_clk_pin_i(ext_pin), .chan_event_i(chan_ev), .wait_mode_i(wait_m),
        .stop_mode_i(stop_m), .break_i(brk), .break_clear_enable_i(bce), .irq_o(irq),
        .wake_o(wake), .ext_pin_force_input_o(force_in));
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc
    // one transfer; waits on hready, no fixed latency assumed
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] d);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {24'h0, ad};
        htrans <= tcc_pkg::TCC_HTRANS_NONSEQ;
        do @(posedge mclk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge mclk_i); while (hready !== 1'b1);
        v = hrdata;
    endtask : xfer
    task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
        xfer(1'b0, ad, 8'h00);
        `CHK(v, {24'h0, e})
    endtask : rdc
    // high byte first, so the low byte comes from the latch
    task automatic cnt(output logic [15:0] c);
        xfer(1'b0, ACH, 8'h00);
        c[15:8] = v[7:0];
        xfer(1'b0, ACL, 8'h00);
        c[7:0] = v[7:0];
    endtask : cnt
    task automatic chan_pulse;
        chan_ev <= 1'b1;
        cyc(1);
        chan_ev <= 1'b0;
        cyc(3);
    endtask : chan_pulse
    // watchdog, far beyond the roughly 2800 cycles the tests need
    initial begin
        cyc(40000);
        failures++;
        print_verdict();
    end
    initial begin
        cyc(8);
        reset_i <= 1'b0;
        cyc(1);
        rdc(AS, 8'h20);
        rdc(AMH, 8'hFF);
        rdc(AML, 8'hFF);
        rdc(ACH, 8'h00);
        `CHK(irq, 1'b0)
        $display("test reset done");
        xfer(1'b1, AS, 8'h30);
        xfer(1'b1, AMH, 8'h00);
        xfer(1'b1, AML, 8'h0F);
        cnt(a);
        `CHK(a, 16'h0000)
        rdc(AS, 8'h20);
        xfer(1'b1, AS, 8'h00);
        cyc(40);
        xfer(1'b1, AS, 8'h20);
        cnt(a);
        `CHK(a <= 16'h000F, 1'b1)
        rdc(AS, 8'hA0);
        xfer(1'b1, AS, 8'hA0);
        rdc(AS, 8'hA0);
        xfer(1'b1, AS, 8'h20);
        rdc(AS, 8'h20);
        xfer(1'b1, AMH, 8'h00);
        xfer(1'b1, AS, 8'h00);
        cyc(40);
        xfer(1'b1, AS, 8'h20);
        rdc(AS, 8'h20);
        xfer(1'b1, AML, 8'h0F);
        xfer(1'b1, AS, 8'h10);
        cyc(40);
        xfer(1'b0, AS, 8'h00);
        `CHK(v[7], 1'b1)
        cyc(40);
        xfer(1'b1, AS, 8'h00);
        xfer(1'b0, AS, 8'h00);
        `CHK(v[7], 1'b1)
        xfer(1'b1, AS, 8'hC0);
        cyc(3);
        `CHK(irq, 1'b1)
        wait_m <= 1'b1;
        cyc(3);
        `CHK(wake, 1'b1)
        wait_m <= 1'b0;
        xfer(1'b1, AS, 8'hE0);
        xfer(1'b0, AS, 8'h00);
        xfer(1'b1, AS, 8'h60);
        cyc(3);
        `CHK(irq, 1'b0)
        xfer(1'b1, AS, 8'h20);
        $display("test overflow done");
        chan_pulse();
        rdc(ACC, 8'h80);
        `CHK(irq, 1'b0)
        brk <= 1'b1;
        xfer(1'b1, ACC, 8'h00);
        rdc(ACC, 8'h80);
        brk <= 1'b0;
        xfer(1'b1, ACC, 8'h40);
        rdc(ACC, 8'h40);
        chan_pulse();
        `CHK(irq, 1'b1)
        brk <= 1'b1;
        bce <= 1'b1;
        xfer(1'b0, ACC, 8'h00);
        xfer(1'b1, ACC, 8'h40);
        brk <= 1'b0;
        bce <= 1'b0;
        rdc(ACC, 8'h40);
        $display("test channel and break done");
        xfer(1'b1, AMH, 8'hFF);
        xfer(1'b1, AML, 8'hFF);
        xfer(1'b1, AS, 8'h10);
        for (int k = 0; k < 2; k++) begin
            stop_m <= (k == 0);
            brk <= (k == 1);
            cyc(4);
            cnt(a);
            cyc(50);
            cnt(b);
            `CHK(b, a)
            stop_m <= 1'b0;
            brk <= 1'b0;
            cyc(10);
            cnt(b);
            `CHK(b > a, 1'b1)
        end
        xfer(1'b1, AS, 8'h16);
        cyc(100);
        xfer(1'b0, ACH, 8'h00);
        a[15:8] = v[7:0];
        cyc(300);
        xfer(1'b0, ACH, 8'h00);
        xfer(1'b0, ACL, 8'h00);
        a[7:0] = v[7:0];
        cnt(b);
        `CHK(b - a >= 16'h0004, 1'b1)
        xfer(1'b1, AS, 8'h26);
        cnt(a);
        xfer(1'b1, ACL, 8'h55);
        xfer(1'b1, ACH, 8'h55);
        cnt(b);
        `CHK(b, a)
        xfer(1'b1, 8'h18, 8'hFF);
        rdc(8'h18, 8'h00);
        rdc(AS, 8'h26);
        $display("test hold and counter read done");
        // slack allows for the bus cycles around each run
        for (int s = 0; s < 7; s++) begin
            xfer(1'b1, AS, 8'h10 | 8'(s));
            cyc(256);
            xfer(1'b1, AS, 8'h20 | 8'(s));
            cnt(a);
            b = 16'(256 >> s);
            `CHK(a + 16'h1 >= b && a <= b + 16'h4, 1'b1)
            `CHK(force_in, 1'b0)
        end
        xfer(1'b1, AS, 8'h17);
        cyc(4);
        `CHK(force_in, 1'b1)
        repeat (5) begin
            ext_pin <= 1'b1;
            cyc(4);
            ext_pin <= 1'b0;
            cyc(4);
        end
        cyc(8);
        xfer(1'b1, AS, 8'h27);
        cnt(a);
        `CHK(a, 16'h0005)
        $display("test clock select done");
        print_verdict();
    end
endmodule : tcc_core_tb
`default_nettype wire
